// [design/chs_defines.vh]
// timing, mode and pin-level constants for the card select and strobe host port
`ifndef CHS_DEFINES_VH
`define CHS_DEFINES_VH

// access modes chosen per command
`define CHS_MODE_MEM 2'h0
`define CHS_MODE_IO 2'h1
`define CHS_MODE_ATA 2'h2

// system clock period in ns
`define CHS_CLK_NS 20

// pio cycle phases in ns (least times)
`define CHS_SETUP_NS 30
`define CHS_STROBE_NS 80
`define CHS_HOLD_NS 30

// ultra dma divider tick period in ns (longest time); the write strobe half period is two ticks
`define CHS_UDMA_HALF_NS 80

// ticks that the stop line stands before dma acknowledge is released
`define CHS_STOP_TICKS 8'h02

// fifo defaults
`define CHS_FIFO_WIDTH 16
`define CHS_FIFO_DEPTH 16

`endif

// [design/chs_fifo.v]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module chs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // fill side
    input wire wr_valid_in,
    output wire wr_ready_out,
    input wire [WIDTH-1:0] wr_data_in,
    // drain side
    output wire rd_valid_out,
    input wire rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_q;
    reg [AW:0] rd_ptr_q;
    wire [AW:0] fill;
    wire do_wr;
    wire do_rd;

    // extra pointer bit tells full from empty without a separate counter
    assign fill = wr_ptr_q - rd_ptr_q;
    assign wr_ready_out = (fill != DEPTH[AW:0]);
    assign rd_valid_out = (fill != {(AW+1){1'b0}});
    assign do_wr = wr_valid_in & wr_ready_out;
    assign do_rd = rd_valid_out & rd_ready_in;
    assign rd_data_out = mem[rd_ptr_q[AW-1:0]];

    // storage has no reset; only pointers carry state
    always @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wr_ptr_q[AW-1:0]] <= wr_data_in;
        end
    end

    // pointers
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule

// [design/chs_host_port.v]
// host controller driving the card select, strobe and ultra dma write pins
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`include "chs_defines.vh"
module chs_host_port #(
    parameter AW = 11,
    parameter HOST_8BIT = 0,
    parameter FIFO_DEPTH = `CHS_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // pio command port
    input wire cmd_valid_in,
    output wire cmd_ready_out,
    input wire cmd_write_in,
    input wire [1:0] cmd_mode_in,
    input wire cmd_byte_in,
    input wire cmd_ctrl_block_in,
    input wire [AW-1:0] cmd_addr_in,
    input wire [15:0] cmd_wdata_in,
    output reg rsp_valid_out,
    output reg [15:0] rsp_rdata_out,
    // ultra dma write stream
    input wire dma_start_in,
    input wire dma_stop_in,
    input wire dma_wr_valid_in,
    output wire dma_wr_ready_out,
    input wire [15:0] dma_wr_data_in,
    output reg dma_busy_out,
    output reg dma_done_out,
    // user status
    input wire role_master_in,
    output reg card_present_out,
    // card pins
    output reg [AW-1:0] card_addr_out,
    output reg low_card_enable_n_out,
    output reg high_card_enable_n_out,
    output reg task_file_select_n_out,
    output reg control_block_select_n_out,
    output reg io_write_n_out,
    output reg io_read_n_out,
    output reg host_write_strobe_out,
    output reg dma_acknowledge_n_out,
    output reg dma_stop_out,
    input wire dma_request_in,
    input wire first_card_detect_n_in,
    input wire second_card_detect_n_in,
    output wire drive_role_select_out,
    output reg drive_role_select_oe_n_out,
    input wire [15:0] card_data_in,
    output reg [15:0] card_data_out,
    output reg card_data_oe_n_out
);
    // ****************************************************************
    // timing and states
    // ****************************************************************
    localparam [7:0] SETUP_CYC = (`CHS_SETUP_NS + `CHS_CLK_NS - 1) / `CHS_CLK_NS;
    localparam [7:0] STROBE_CYC = (`CHS_STROBE_NS + `CHS_CLK_NS - 1) / `CHS_CLK_NS;
    localparam [7:0] HOLD_CYC = (`CHS_HOLD_NS + `CHS_CLK_NS - 1) / `CHS_CLK_NS;
    localparam [7:0] HALF_CYC = `CHS_UDMA_HALF_NS / `CHS_CLK_NS;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_SETUP = 3'h1;
    localparam [2:0] S_STROBE = 3'h2;
    localparam [2:0] S_HOLD = 3'h3;
    localparam [2:0] S_DREQ = 3'h4;
    localparam [2:0] S_BURST = 3'h5;
    localparam [2:0] S_DSTOP = 3'h6;

    // enables {high_n, low_n} and lowest address bit for one access
    function [2:0] chs_lane_decode;
        input is_byte;
        input odd;
        begin
            if (!is_byte) begin
                chs_lane_decode = 3'h0; // word: both enables, a0 low
            end else if (!odd) begin
                chs_lane_decode = 3'h4; // even byte: low enable only, a0 low
            end else if (HOST_8BIT != 0) begin
                chs_lane_decode = 3'h5; // odd byte muxed to low lane, a0 high
            end else begin
                chs_lane_decode = 3'h3; // odd byte: high enable only, on high lane
            end
        end
    endfunction

    reg [2:0] state_q;
    reg [7:0] cnt_q;
    reg [7:0] div_q;
    reg [7:0] stop_cnt_q;
    reg write_q;
    reg byte_q;
    reg odd_hi_q;
    reg loaded_q;
    reg stop_req_q;
    reg [1:0] mode_q;
    reg dreq_s1_q;
    reg dreq_s2_q;
    reg [1:0] cd_s1_q;
    reg [1:0] cd_s2_q;
    reg [15:0] din_s1_q;
    reg [15:0] din_s2_q;
    wire tick;
    wire fifo_rd_valid;
    wire fifo_rd_ready;
    wire [15:0] fifo_rd_data;
    wire [2:0] lanes;
    wire hi_only;

    assign lanes = chs_lane_decode(cmd_byte_in, cmd_addr_in[0]);
    assign hi_only = lanes[1] & ~lanes[2]; // byte travels on the high lane only
    assign cmd_ready_out = (state_q == S_IDLE) && !dma_start_in;
    // divider tick paces the strobe; counter is reloaded in idle and while waiting for a request, and free-runs in every other state
    assign tick = (div_q == 8'h00);
    // pop only while no word is waiting on the pins
    assign fifo_rd_ready = (state_q == S_BURST) && tick && !loaded_q && !stop_req_q;
    // role select: memory mode grounds it, ata master grounds, slave open
    assign drive_role_select_out = 1'b0;

    // ****************************************************************
    // data fifo
    // ****************************************************************
    chs_fifo #(
        .WIDTH(`CHS_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .wr_valid_in(dma_wr_valid_in),
        .wr_ready_out(dma_wr_ready_out),
        .wr_data_in(dma_wr_data_in),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(fifo_rd_ready),
        .rd_data_out(fifo_rd_data)
    );

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // card pins are asynchronous to clk_sys_in; second stage alone is read
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dreq_s1_q <= 1'b0;
            dreq_s2_q <= 1'b0;
            cd_s1_q <= 2'h3;
            cd_s2_q <= 2'h3;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
            card_present_out <= 1'b0;
        end else begin
            dreq_s1_q <= dma_request_in;
            dreq_s2_q <= dreq_s1_q;
            cd_s1_q <= {second_card_detect_n_in, first_card_detect_n_in};
            cd_s2_q <= cd_s1_q;
            din_s1_q <= card_data_in;
            din_s2_q <= din_s1_q;
            card_present_out <= (cd_s2_q == 2'h0);
        end
    end

    // role select drive follows the last mode used; slave leaves it open
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drive_role_select_oe_n_out <= 1'b0;
        end else if (mode_q == `CHS_MODE_ATA) begin
            drive_role_select_oe_n_out <= !role_master_in;
        end else begin
            drive_role_select_oe_n_out <= 1'b0;
        end
    end

    // ****************************************************************
    // access sequencer
    // ****************************************************************
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= S_IDLE;
            cnt_q <= 8'h00;
            div_q <= 8'h00;
            stop_cnt_q <= 8'h00;
            write_q <= 1'b0;
            byte_q <= 1'b0;
            odd_hi_q <= 1'b0;
            loaded_q <= 1'b0;
            stop_req_q <= 1'b0;
            mode_q <= `CHS_MODE_MEM;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 16'h0000;
            dma_busy_out <= 1'b0;
            dma_done_out <= 1'b0;
            card_addr_out <= {AW{1'b0}};
            low_card_enable_n_out <= 1'b1;
            high_card_enable_n_out <= 1'b1;
            task_file_select_n_out <= 1'b1;
            control_block_select_n_out <= 1'b1;
            io_write_n_out <= 1'b1;
            io_read_n_out <= 1'b1;
            host_write_strobe_out <= 1'b1;
            dma_acknowledge_n_out <= 1'b1;
            dma_stop_out <= 1'b0;
            card_data_out <= 16'h0000;
            card_data_oe_n_out <= 1'b1;
        end else begin
            rsp_valid_out <= 1'b0;
            dma_done_out <= 1'b0;
            // a stop arriving while waiting for a request or in the burst is kept until idle
            if (dma_stop_in && (state_q == S_DREQ || state_q == S_BURST)) begin
                stop_req_q <= 1'b1;
            end
            div_q <= tick ? HALF_CYC - 8'h01 : div_q - 8'h01;
            case (state_q)
                S_IDLE: begin
                    div_q <= HALF_CYC - 8'h01;
                    stop_req_q <= 1'b0;
                    if (dma_start_in) begin
                        dma_busy_out <= 1'b1;
                        state_q <= S_DREQ;
                    end else if (cmd_valid_in) begin
                        mode_q <= cmd_mode_in;
                        write_q <= cmd_write_in;
                        byte_q <= cmd_byte_in;
                        odd_hi_q <= hi_only;
                        if (cmd_mode_in == `CHS_MODE_ATA) begin
                            card_addr_out <= cmd_addr_in;
                            task_file_select_n_out <= cmd_ctrl_block_in;
                            control_block_select_n_out <= !cmd_ctrl_block_in;
                        end else begin
                            // same decode in memory and io mode
                            card_addr_out <= {cmd_addr_in[AW-1:1], lanes[0]};
                            low_card_enable_n_out <= lanes[1];
                            high_card_enable_n_out <= lanes[2];
                        end
                        // odd byte for the high lane is moved up there
                        card_data_out <= hi_only ? {cmd_wdata_in[7:0], 8'h00} : cmd_wdata_in;
                        card_data_oe_n_out <= !cmd_write_in;
                        cnt_q <= SETUP_CYC - 8'h01;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        io_write_n_out <= !write_q;
                        io_read_n_out <= write_q;
                        cnt_q <= STROBE_CYC - 8'h01;
                        state_q <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        io_write_n_out <= 1'b1;
                        io_read_n_out <= 1'b1;
                        if (!byte_q) begin
                            rsp_rdata_out <= din_s2_q;
                        end else if (odd_hi_q) begin
                            rsp_rdata_out <= {8'h00, din_s2_q[15:8]};
                        end else begin
                            rsp_rdata_out <= {8'h00, din_s2_q[7:0]};
                        end
                        cnt_q <= HOLD_CYC - 8'h01;
                        state_q <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        // everything negated between accesses
                        low_card_enable_n_out <= 1'b1;
                        high_card_enable_n_out <= 1'b1;
                        task_file_select_n_out <= 1'b1;
                        control_block_select_n_out <= 1'b1;
                        card_data_oe_n_out <= 1'b1;
                        rsp_valid_out <= !write_q;
                        state_q <= S_IDLE;
                    end
                end
                S_DREQ: begin
                    mode_q <= `CHS_MODE_ATA;
                    div_q <= HALF_CYC - 8'h01;
                    // acknowledge only answers a request seen
                    if (dreq_s2_q) begin
                        dma_acknowledge_n_out <= 1'b0;
                        card_data_oe_n_out <= 1'b0;
                        loaded_q <= 1'b0;
                        state_q <= S_BURST;
                    end else if (stop_req_q) begin
                        dma_busy_out <= 1'b0;
                        dma_done_out <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_BURST: begin
                    if (tick) begin
                        if (stop_req_q && !loaded_q) begin
                            dma_stop_out <= 1'b1;
                            stop_cnt_q <= `CHS_STOP_TICKS;
                            state_q <= S_DSTOP;
                        end else if (loaded_q) begin
                            // each edge, either direction, hands one word over
                            host_write_strobe_out <= !host_write_strobe_out;
                            loaded_q <= 1'b0;
                        end else if (fifo_rd_valid) begin
                            card_data_out <= fifo_rd_data;
                            loaded_q <= 1'b1;
                        end
                        // fifo empty: strobe holds still, burst pauses
                    end
                end
                S_DSTOP: begin
                    if (tick) begin
                        stop_cnt_q <= stop_cnt_q - 8'h01;
                        if (stop_cnt_q == 8'h01) begin
                            dma_stop_out <= 1'b0;
                            dma_acknowledge_n_out <= 1'b1;
                            host_write_strobe_out <= 1'b1;
                            card_data_oe_n_out <= 1'b1;
                            dma_busy_out <= 1'b0;
                            dma_done_out <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// [verif/chs_card_model.sv]
// behavioural card: byte steering, chip selects, ultra dma capture
`timescale 1ns/100ps
module chs_card_model (
    // host pins
    input wire [10:0] addr_in,
    input wire ce_lo_n_in,
    input wire ce_hi_n_in,
    input wire cs0_n_in,
    input wire cs1_n_in,
    input wire wr_n_in,
    input wire rd_n_in,
    input wire strobe_in,
    input wire ack_n_in,
    input wire stop_in,
    input wire [15:0] d_in,
    input wire role_in,
    // bench controls
    input wire seat1_in,
    input wire seat2_in,
    input wire want_in,
    // card pins
    output wire dreq_out,
    output wire cd1_n_out,
    output wire cd2_n_out,
    output wire master_out,
    output wire [15:0] d_out
);
// ****************************************
// storage and steering
// ****************************************
reg [15:0] mem [0:15];
reg [15:0] tf [0:7];
reg [15:0] ctl_q;
reg [15:0] last_q = 16'h00a5;
reg burst_q = 1'b0;
reg [15:0] cap [0:63];
integer ncap = 0;
wire [3:0] wi = addr_in[4:1];
wire [15:0] w = mem[wi];
wire sel = !ce_lo_n_in || !ce_hi_n_in || !cs0_n_in || !cs1_n_in;
// detect grounded when seated; driven high when not, in place of the host pull-up
assign cd1_n_out = !seat1_in;
assign cd2_n_out = !seat2_in;
assign master_out = !role_in;
assign dreq_out = want_in;
// undriven lanes show the inverse of the last value, not a stale copy
wire [15:0] rd = !cs0_n_in ? tf[addr_in[2:0]] : !cs1_n_in ? ctl_q :
    !ce_lo_n_in && !ce_hi_n_in ? w : !ce_hi_n_in ? {w[15:8], ~last_q[7:0]} :
    addr_in[0] ? {~last_q[15:8], w[15:8]} : {~last_q[15:8], w[7:0]};
assign d_out = (!rd_n_in && sel) ? rd : ~last_q;
always @(posedge rd_n_in) last_q <= rd;
// writes latch on the trailing edge of the write strobe
always @(posedge wr_n_in) begin
    if (!cs0_n_in) tf[addr_in[2:0]] <= d_in;
    else if (!cs1_n_in) ctl_q <= d_in;
    else if (!ce_lo_n_in && !ce_hi_n_in) mem[wi] <= d_in;
    else if (!ce_hi_n_in) mem[wi][15:8] <= d_in[15:8];
    else if (!ce_lo_n_in && addr_in[0]) mem[wi][15:8] <= d_in[7:0];
    else if (!ce_lo_n_in) mem[wi][7:0] <= d_in[7:0];
end
// burst opens on ack and ends at once on stop
always @(negedge ack_n_in or posedge stop_in) burst_q <= !stop_in;
// every strobe edge takes one 16-bit word; a quiet strobe is a pause
always @(strobe_in) if (burst_q && !ack_n_in) begin
    cap[ncap] = d_in;
    ncap = ncap + 1;
end
endmodule

// [verif/chs_host_port_assertions.sv]
// checker of the host port pin rules
`timescale 1ns/100ps
module chs_host_port_assertions #(
    parameter AW = 11
) (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // card pins and status
    input wire rsp_valid_out,
    input wire io_read_n_out,
    input wire low_card_enable_n_out,
    input wire high_card_enable_n_out,
    input wire task_file_select_n_out,
    input wire control_block_select_n_out,
    input wire host_write_strobe_out,
    input wire dma_acknowledge_n_out,
    input wire dma_stop_out,
    input wire dma_request_in,
    input wire first_card_detect_n_in,
    input wire second_card_detect_n_in,
    input wire card_present_out,
    input wire [AW-1:0] card_addr_out
);
// ****************************************
// pin relations
// ****************************************
default clocking cb @(posedge clk_sys_in); endclocking
default disable iff (!rst_n_in);
a_dma_acknowledge_no_select: assert property (
    !dma_acknowledge_n_out |-> task_file_select_n_out && control_block_select_n_out) else $error("select during ack");
a_strobe_needs_ack: assert property (
    $changed(host_write_strobe_out) |-> !$past(dma_acknowledge_n_out)) else $error("strobe moved without ack");
a_strobe_tick_hold: assert property (
    $changed(host_write_strobe_out) && !dma_acknowledge_n_out |=> $stable(host_write_strobe_out)[*3])
    else $error("strobe edge faster than a tick");
a_stop_in_burst: assert property (
    dma_stop_out |-> !dma_acknowledge_n_out) else $error("stop outside a burst");
a_ack_after_req: assert property (
    $fell(dma_acknowledge_n_out) |-> $past(dma_request_in, 3)) else $error("ack without request");
a_ata_no_enables: assert property (
    !(task_file_select_n_out && control_block_select_n_out) |-> low_card_enable_n_out && high_card_enable_n_out)
    else $error("card enable with chip select");
a_word_even_addr: assert property (
    !low_card_enable_n_out && !high_card_enable_n_out |-> !card_addr_out[0]) else $error("word access at odd address");
a_read_strobe_len: assert property (
    $fell(io_read_n_out) |-> !io_read_n_out[*4] ##1 io_read_n_out ##2 rsp_valid_out) else $error("read cycle shape");
a_present_both: assert property (
    card_present_out |-> !$past(first_card_detect_n_in, 3) && !$past(second_card_detect_n_in, 3))
    else $error("present with a detect line high");
c_burst: cover property ($fell(dma_acknowledge_n_out));
c_read: cover property (rsp_valid_out);
c_stop: cover property (dma_stop_out);
c_present: cover property ($rose(card_present_out));
endmodule
bind chs_host_port chs_host_port_assertions #(.AW(AW)) chs_host_port_assertions_i (.*);

// [verif/chs_host_port_tb.sv]
// self-checking bench for the card host port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module chs_host_port_tb;
reg clk_sys_in = 1'b0;
reg rst_n_in = 1'b0;
reg cmd_valid_in = 1'b0;
reg cmd_write_in = 1'b0;
reg [1:0] cmd_mode_in = 2'h0;
reg cmd_byte_in = 1'b0;
reg cmd_ctrl_block_in = 1'b0;
reg [10:0] cmd_addr_in = 11'h000;
reg [15:0] cmd_wdata_in = 16'h0000;
reg dma_start_in = 1'b0;
reg dma_stop_in = 1'b0;
reg dma_wr_valid_in = 1'b0;
reg [15:0] dma_wr_data_in = 16'h0000;
reg role_master_in = 1'b1;
reg seat1 = 1'b1, seat2 = 1'b1, want = 1'b0;
wire cmd_ready_out, rsp_valid_out, dma_wr_ready_out, dma_busy_out, dma_done_out, card_present_out, master;
wire [15:0] rsp_rdata_out, card_data_out, card_d, card_data_in;
wire [10:0] card_addr_out;
wire low_card_enable_n_out, high_card_enable_n_out, task_file_select_n_out, control_block_select_n_out;
wire io_write_n_out, io_read_n_out, host_write_strobe_out, dma_acknowledge_n_out, dma_stop_out;
wire dma_request_in, first_card_detect_n_in, second_card_detect_n_in;
wire drive_role_select_out, drive_role_select_oe_n_out, card_data_oe_n_out;
integer error_cnt = 0, check_count = 0, cyc = 0, i, n;
reg [15:0] rd;
// shared data bus and the role line with its pull-up inside the card
assign card_data_in = !card_data_oe_n_out ? card_data_out : card_d;
wire role_w = drive_role_select_oe_n_out ? 1'b1 : drive_role_select_out;
chs_host_port chs_host_port_i (.*);
chs_card_model chs_card_model_i (.addr_in(card_addr_out), .ce_lo_n_in(low_card_enable_n_out),
    .ce_hi_n_in(high_card_enable_n_out), .cs0_n_in(task_file_select_n_out), .cs1_n_in(control_block_select_n_out),
    .wr_n_in(io_write_n_out), .rd_n_in(io_read_n_out), .strobe_in(host_write_strobe_out),
    .ack_n_in(dma_acknowledge_n_out), .stop_in(dma_stop_out), .d_in(card_data_in), .role_in(role_w),
    .seat1_in(seat1), .seat2_in(seat2), .want_in(want), .dreq_out(dma_request_in),
    .cd1_n_out(first_card_detect_n_in), .cd2_n_out(second_card_detect_n_in), .master_out(master), .d_out(card_d));
// ****************************************
// clock, watchdog and closing
// ****************************************
initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
end
// the whole run needs a few hundred cycles; a hang ends here
always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
        error_cnt++;
        stop_test;
    end
end
task stop_test;
    begin
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
// one pio access; the request holds until the design takes it
task pio(input w, input [1:0] m, input b, input c, input [10:0] a, input [15:0] wd);
    begin
        @(posedge clk_sys_in);
        {cmd_valid_in, cmd_write_in, cmd_mode_in, cmd_byte_in, cmd_ctrl_block_in, cmd_addr_in, cmd_wdata_in} <=
            {1'b1, w, m, b, c, a, wd};
        @(negedge clk_sys_in);
        while (cmd_ready_out !== 1'b1) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
        cmd_valid_in <= 1'b0;
        @(negedge clk_sys_in);
        for (n = 0; n < 40 && (w ? cmd_ready_out : rsp_valid_out) !== 1'b1; n++) @(negedge clk_sys_in);
        rd = rsp_rdata_out;
        `CHK("pio_end", 1'b1, n < 40)
    end
endtask
// ****************************************
// scenarios
// ****************************************
task t_detect;
    begin
        `CHK("strobe_idle", 1'b1, host_write_strobe_out)
        `CHK("enables_idle", 4'hf, {low_card_enable_n_out, high_card_enable_n_out, task_file_select_n_out,
            control_block_select_n_out})
        repeat (6) @(posedge clk_sys_in);
        `CHK("present", 1'b1, card_present_out)
        seat2 <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        `CHK("half_seated", 1'b0, card_present_out)
        seat2 <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
    end
endtask
// word, even byte and odd byte in memory then io mode
task t_lanes;
    reg [10:0] a;
    begin
        for (i = 0; i < 2; i++) begin
            a = 11'h010 + 11'h004 * i;
            pio(1, i, 0, 0, a, 16'h1234 + i);
            pio(0, i, 0, 0, a, 16'h0000);
            `CHK("word_rd", 16'h1234 + i, rd)
            pio(1, i, 1, 0, a + 11'h002, 16'h005a);
            pio(1, i, 1, 0, a + 11'h003, 16'h00c3);
            pio(0, i, 0, 0, a + 11'h002, 16'h0000);
            `CHK("bytes_word", 16'hc35a, rd)
            pio(0, i, 1, 0, a + 11'h003, 16'h0000);
            `CHK("odd_byte", 16'h00c3, rd)
            pio(0, i, 1, 0, a + 11'h002, 16'h0000);
            `CHK("even_byte", 16'h005a, rd)
        end
    end
endtask
task t_ata;
    begin
        pio(1, 2, 0, 0, 11'h006, 16'h0011);
        pio(1, 2, 0, 1, 11'h006, 16'h0004);
        pio(0, 2, 0, 0, 11'h006, 16'h0000);
        `CHK("task_file", 16'h0011, rd)
        pio(0, 2, 0, 1, 11'h006, 16'h0000);
        `CHK("ctrl_block", 16'h0004, rd)
        `CHK("role_master", 1'b1, master)
        @(posedge clk_sys_in);
        role_master_in <= 1'b0;
        pio(0, 2, 0, 0, 11'h006, 16'h0000);
        `CHK("role_slave", 1'b0, master)
        @(posedge clk_sys_in);
        role_master_in <= 1'b1;
    end
endtask
// fill the fifo until it refuses, burst it out, pause, resume, stop
task t_dma;
    begin
        @(posedge clk_sys_in);
        dma_wr_valid_in <= 1'b1;
        dma_wr_data_in <= 16'ha000;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_sys_in);
            if (dma_wr_ready_out !== 1'b1) break;
            @(posedge clk_sys_in);
            dma_wr_data_in <= 16'ha001 + i;
        end
        @(posedge clk_sys_in);
        dma_wr_valid_in <= 1'b0;
        `CHK("fifo_depth", 16, i)
        want <= 1'b1;
        dma_start_in <= 1'b1;
        @(posedge clk_sys_in);
        dma_start_in <= 1'b0;
        for (n = 0; n < 50 && dma_acknowledge_n_out !== 1'b0; n++) @(negedge clk_sys_in);
        `CHK("ack_seen", 1'b1, n < 50)
        @(posedge clk_sys_in);
        want <= 1'b0;
        for (n = 0; n < 400 && chs_card_model_i.ncap < 16; n++) @(negedge clk_sys_in);
        repeat (40) @(posedge clk_sys_in);
        `CHK("paused", 16, chs_card_model_i.ncap)
        for (i = 16; i < 18; i++) begin
            dma_wr_valid_in <= 1'b1;
            dma_wr_data_in <= 16'ha000 + i;
            @(posedge clk_sys_in);
            dma_wr_valid_in <= 1'b0;
            @(posedge clk_sys_in);
        end
        for (n = 0; n < 100 && chs_card_model_i.ncap < 18; n++) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
        dma_stop_in <= 1'b1;
        @(posedge clk_sys_in);
        dma_stop_in <= 1'b0;
        for (n = 0; n < 60 && dma_done_out !== 1'b1; n++) @(negedge clk_sys_in);
        `CHK("done", 1'b1, n < 60)
        @(negedge clk_sys_in);
        `CHK("ack_off", 2'h2, {dma_acknowledge_n_out, dma_busy_out})
        `CHK("words", 18, chs_card_model_i.ncap)
        for (i = 0; i < 18; i++) `CHK("word", 16'ha000 + i, chs_card_model_i.cap[i])
        // stop while still waiting for a request ends the burst at once, no ack
        @(posedge clk_sys_in);
        dma_start_in <= 1'b1;
        @(posedge clk_sys_in);
        {dma_start_in, dma_stop_in} <= 2'h1;
        @(posedge clk_sys_in);
        dma_stop_in <= 1'b0;
        for (n = 0; n < 10 && dma_done_out !== 1'b1; n++) @(negedge clk_sys_in);
        `CHK("stop_no_req", 2'h3, {n < 10, dma_acknowledge_n_out})
    end
endtask
initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_detect;
    t_lanes;
    t_ata;
    t_dma;
    stop_test;
end
endmodule
